// ==== hdl/fics_map.svh ====
// Purpose: Offsets, codes, reset values and timing counts of the flash command sequencer
// Assumes: Included by its bare name from design and bench files
// Notes:   Definitions only
`ifndef FICS_MAP_SVH
`define FICS_MAP_SVH

// ==========================================================================
// Register offsets on the special function register bus
`define FICS_ADDR_LOW_OFS     8'hf9
`define FICS_ADDR_HIGH_OFS    8'hfa
`define FICS_DATA_OFS         8'hfb
`define FICS_CMD_CHECK_OFS    8'hfc
`define FICS_CMD_VALUE_OFS    8'hfd

// ==========================================================================
// Reset and parked values
`define FICS_ADDR_LOW_RST     8'hff
`define FICS_ADDR_HIGH_RST    6'h3f
`define FICS_DATA_RST         8'h00
`define FICS_CMD_VALUE_RST    8'h00
`define FICS_CMD_CHECK_RST    8'hff

// ==========================================================================
// Command codes written to the command value register
`define FICS_CODE_UNLOCK      8'hf0
`define FICS_CODE_TRIGGER     8'he1
`define FICS_CODE_ERASE       8'hd2
`define FICS_CODE_PROGRAM     8'hb4
`define FICS_CODE_RST_KEEP    8'h87
`define FICS_CODE_RST_RELOAD  8'h78

// ==========================================================================
// Field layout
`define FICS_ADDR_HIGH_BITS   6
`define FICS_SECTOR_LSB       7
`define FICS_VECTOR_SHIFT     9

// ==========================================================================
// Timing
`define FICS_UNLOCK_CLOCKS    22
`define FICS_MIN_FREQ_MHZ     8'h01

`endif

// ==== hdl/fics_pkg.sv ====
// Purpose: Types of the flash command sequencer
// Assumes: Nothing
// Notes:   Constants live in fics_map.svh
package fics_pkg;

	// ======================================================================
	// Sequencer state, Gray coded along locked, unlocked, mode selected
	typedef enum logic [1:0] {
		FICS_LOCKED   = 2'b00,
		FICS_UNLOCKED = 2'b01,
		FICS_MODE_SET = 2'b11
	} fics_state_t;

	// Selected flash operation
	typedef enum logic [1:0] {
		FICS_OP_NONE  = 2'b00,
		FICS_OP_ERASE = 2'b01,
		FICS_OP_PROG  = 2'b10
	} fics_op_t;

endpackage : fics_pkg

// ==== hdl/fics_sequencer.sv ====
// Purpose: Unlock, mode select and trigger sequencer for in-application flash writes
// Assumes: One register write per cycle; flash array takes the start pulses
// Notes:   Read data answers one cycle after the read strobe
`timescale 1ns/100ps
`default_nettype none
`include "fics_map.svh"

module fics_sequencer #(
	parameter int UNLOCK_CLOCKS = `FICS_UNLOCK_CLOCKS
) (
	// Clock and resets
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        por_n,
	// Register bus
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata,
	// Clock and stored options
	input  wire logic [7:0]  cpu_freq_setting,
	input  wire logic        alt_boot_vector_enable,
	input  wire logic [3:0]  alt_boot_vector_select,
	// Flash array requests
	output logic             flash_erase_start,
	output logic             flash_prog_start,
	output logic      [13:0] flash_op_addr,
	output logic      [7:0]  flash_op_data,
	// Reset requests and status
	output logic             soft_reset_req,
	output logic             soft_reset_reload,
	output logic      [15:0] reset_vector,
	output logic             unlocked
);

	// ======================================================================
	// State
	fics_pkg::fics_state_t state_reg, state_next;
	fics_pkg::fics_op_t    op_reg, op_next;
	logic [7:0]  addr_low_reg, addr_low_next;
	logic [5:0]  addr_high_reg, addr_high_next;
	logic [7:0]  data_reg, data_next;
	logic [7:0]  cmd_value_reg, cmd_value_next;
	logic [7:0]  cmd_check_reg, cmd_check_next;
	logic [7:0]  rdata_reg, rdata_next;
	logic        erase_reg, erase_next;
	logic        prog_reg, prog_next;
	logic [13:0] op_addr_reg, op_addr_next;
	logic [7:0]  op_data_reg, op_data_next;
	logic        srst_reg, srst_next;
	logic        reload_reg, reload_next;
	logic        boot_alt_reg, boot_alt_next;
	logic [15:0] vector_reg, vector_next;
	logic        unlocked_reg, unlocked_next;

	logic wr_value;
	logic wr_check;
	logic code_ok;
	logic freq_ok;
	logic timer_start;
	logic timer_stop;
	logic expire;

	// ======================================================================
	// Decode
	assign wr_value = sfr_wr && (sfr_addr == `FICS_CMD_VALUE_OFS);
	assign wr_check = sfr_wr && (sfr_addr == `FICS_CMD_CHECK_OFS);
	assign code_ok  = (sfr_wdata == ~cmd_value_reg);
	assign freq_ok  = (cpu_freq_setting >= `FICS_MIN_FREQ_MHZ);

	// Unlock expiry counter
	fics_unlock_timer #(
		.LIMIT (UNLOCK_CLOCKS)
	) u_timer (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.start    (timer_start),
		.stop     (timer_stop),
		.expire   (expire)
	);

	// ======================================================================
	// Sequencer next state
	always_comb begin
		state_next     = state_reg;
		op_next        = op_reg;
		addr_low_next  = addr_low_reg;
		addr_high_next = addr_high_reg;
		data_next      = data_reg;
		cmd_value_next = cmd_value_reg;
		cmd_check_next = cmd_check_reg;
		erase_next     = 1'b0;
		prog_next      = 1'b0;
		op_addr_next   = op_addr_reg;
		op_data_next   = op_data_reg;
		srst_next      = 1'b0;
		reload_next    = reload_reg;
		timer_start    = 1'b0;
		timer_stop     = 1'b0;
		// Plain register writes
		if (sfr_wr && sfr_addr == `FICS_DATA_OFS)
			data_next = sfr_wdata;
		if (sfr_wr && state_reg != fics_pkg::FICS_LOCKED) begin
			if (sfr_addr == `FICS_ADDR_LOW_OFS)
				addr_low_next = sfr_wdata;
			if (sfr_addr == `FICS_ADDR_HIGH_OFS)
				addr_high_next = sfr_wdata[5:0];
		end
		if (wr_value) begin
			cmd_value_next = sfr_wdata;
			// Unknown value while unlocked drops the unlock at once
			if (state_reg != fics_pkg::FICS_LOCKED &&
			    sfr_wdata != `FICS_CODE_UNLOCK && sfr_wdata != `FICS_CODE_TRIGGER &&
			    sfr_wdata != `FICS_CODE_ERASE && sfr_wdata != `FICS_CODE_PROGRAM &&
			    sfr_wdata != `FICS_CODE_RST_KEEP && sfr_wdata != `FICS_CODE_RST_RELOAD) begin
				state_next = fics_pkg::FICS_LOCKED;
				op_next    = fics_pkg::FICS_OP_NONE;
				timer_stop = 1'b1;
			end
		end
		// Check write acts on the value held before it
		if (wr_check) begin
			cmd_check_next = sfr_wdata;
			if (!code_ok) begin
				state_next = fics_pkg::FICS_LOCKED;
				op_next    = fics_pkg::FICS_OP_NONE;
				timer_stop = 1'b1;
			end else begin
				case (cmd_value_reg)
					`FICS_CODE_UNLOCK: begin
						state_next  = fics_pkg::FICS_UNLOCKED;
						op_next     = fics_pkg::FICS_OP_NONE;
						timer_start = 1'b1;
					end
					`FICS_CODE_ERASE, `FICS_CODE_PROGRAM: begin
						if (state_reg != fics_pkg::FICS_LOCKED) begin
							state_next = fics_pkg::FICS_MODE_SET;
							op_next    = (cmd_value_reg == `FICS_CODE_ERASE) ?
							             fics_pkg::FICS_OP_ERASE :
							             fics_pkg::FICS_OP_PROG;
						end
					end
					`FICS_CODE_TRIGGER: begin
						if (state_reg == fics_pkg::FICS_MODE_SET && freq_ok) begin
							erase_next = (op_reg == fics_pkg::FICS_OP_ERASE);
							prog_next  = (op_reg == fics_pkg::FICS_OP_PROG);
							op_data_next = data_reg;
							// Erase drops the in-sector bits
							if (op_reg == fics_pkg::FICS_OP_ERASE)
								op_addr_next = {addr_high_reg,
								                addr_low_reg[7:`FICS_SECTOR_LSB],
								                7'h00};
							else
								op_addr_next = {addr_high_reg, addr_low_reg};
							if (op_reg == fics_pkg::FICS_OP_PROG)
								data_next = `FICS_DATA_RST;
						end
						if (state_reg != fics_pkg::FICS_LOCKED) begin
							addr_low_next  = `FICS_ADDR_LOW_RST;
							addr_high_next = `FICS_ADDR_HIGH_RST;
						end
						state_next = fics_pkg::FICS_LOCKED;
						op_next    = fics_pkg::FICS_OP_NONE;
						timer_stop = 1'b1;
					end
					`FICS_CODE_RST_KEEP, `FICS_CODE_RST_RELOAD: begin
						if (state_reg != fics_pkg::FICS_LOCKED) begin
							srst_next   = 1'b1;
							reload_next = (cmd_value_reg == `FICS_CODE_RST_RELOAD);
						end
						state_next = fics_pkg::FICS_LOCKED;
						op_next    = fics_pkg::FICS_OP_NONE;
						timer_stop = 1'b1;
					end
					default: begin
						state_next = fics_pkg::FICS_LOCKED;
						op_next    = fics_pkg::FICS_OP_NONE;
						timer_stop = 1'b1;
					end
				endcase
			end
		end
		// Expiry overrides state, mode and command value this cycle except on a new unlock, which restarts it
		if (expire && !timer_start) begin
			state_next     = fics_pkg::FICS_LOCKED;
			op_next        = fics_pkg::FICS_OP_NONE;
			cmd_value_next = `FICS_CMD_VALUE_RST;
		end
		// Status flop follows the state so the pin needs no decode after the register
		unlocked_next = (state_next != fics_pkg::FICS_LOCKED);
	end

	// ======================================================================
	// Boot vector choice survives system reset; power-on or a reload soft reset rearms it
	always_comb begin
		boot_alt_next = boot_alt_reg;
		if (srst_reg)
			boot_alt_next = reload_reg;
		vector_next = 16'h0000;
		if (boot_alt_reg && alt_boot_vector_enable)
			vector_next = 16'({alt_boot_vector_select, 9'h000});
	end

	// Read data, registered; unmapped offsets read zero
	always_comb begin
		rdata_next = rdata_reg;
		if (sfr_rd) begin
			case (sfr_addr)
				`FICS_ADDR_LOW_OFS:  rdata_next = addr_low_reg;
				`FICS_ADDR_HIGH_OFS: rdata_next = {2'b00, addr_high_reg};
				`FICS_DATA_OFS:      rdata_next = data_reg;
				`FICS_CMD_CHECK_OFS: rdata_next = cmd_check_reg;
				`FICS_CMD_VALUE_OFS: rdata_next = cmd_value_reg;
				default:             rdata_next = 8'h00;
			endcase
		end
	end

	// ======================================================================
	// Registers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_reg     <= fics_pkg::FICS_LOCKED;
			op_reg        <= fics_pkg::FICS_OP_NONE;
			addr_low_reg  <= `FICS_ADDR_LOW_RST;
			addr_high_reg <= `FICS_ADDR_HIGH_RST;
			data_reg      <= `FICS_DATA_RST;
			cmd_value_reg <= `FICS_CMD_VALUE_RST;
			cmd_check_reg <= `FICS_CMD_CHECK_RST;
			rdata_reg     <= 8'h00;
			erase_reg     <= 1'b0;
			prog_reg      <= 1'b0;
			op_addr_reg   <= 14'h0000;
			op_data_reg   <= 8'h00;
			srst_reg      <= 1'b0;
			reload_reg    <= 1'b0;
			vector_reg    <= 16'h0000;
			unlocked_reg  <= 1'b0;
		end else begin
			state_reg     <= state_next;
			op_reg        <= op_next;
			addr_low_reg  <= addr_low_next;
			addr_high_reg <= addr_high_next;
			data_reg      <= data_next;
			cmd_value_reg <= cmd_value_next;
			cmd_check_reg <= cmd_check_next;
			rdata_reg     <= rdata_next;
			erase_reg     <= erase_next;
			prog_reg      <= prog_next;
			op_addr_reg   <= op_addr_next;
			op_data_reg   <= op_data_next;
			srst_reg      <= srst_next;
			reload_reg    <= reload_next;
			vector_reg    <= vector_next;
			unlocked_reg  <= unlocked_next;
		end
	end

	// Power-on only flop
	always_ff @(posedge core_clk) begin
		if (!por_n)
			boot_alt_reg <= 1'b1;
		else
			boot_alt_reg <= boot_alt_next;
	end

	// Outputs
	assign sfr_rdata         = rdata_reg;
	assign flash_erase_start = erase_reg;
	assign flash_prog_start  = prog_reg;
	assign flash_op_addr     = op_addr_reg;
	assign flash_op_data     = op_data_reg;
	assign soft_reset_req    = srst_reg;
	assign soft_reset_reload = reload_reg;
	assign reset_vector      = vector_reg;
	assign unlocked          = unlocked_reg;

endmodule : fics_sequencer
`default_nettype wire

// ==== hdl/fics_unlock_timer.sv ====
// Purpose: Counts CPU clocks after an unlock and flags the expiry
// Assumes: start and stop come from logic on core_clk
// Notes:   expire is combinational, one cycle before the count ends
`timescale 1ns/100ps
`default_nettype none
`include "fics_map.svh"

module fics_unlock_timer #(
	parameter int LIMIT = `FICS_UNLOCK_CLOCKS
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst_n,
	// Control
	input  wire logic start,
	input  wire logic stop,
	// Status
	output logic      expire
);

	localparam logic [7:0] LAST = 8'(LIMIT - 1);

	logic       run_reg;
	logic       run_next;
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;

	// ======================================================================
	// Next value; a restart wins over a stop so a fresh unlock gets full time
	always_comb begin
		run_next = run_reg;
		cnt_next = cnt_reg;
		if (start) begin
			run_next = 1'b1;
			cnt_next = 8'h00;
		end else if (stop || expire) begin
			run_next = 1'b0;
		end else if (run_reg) begin
			cnt_next = cnt_reg + 8'h01;
		end
	end

	// Lock lands on the LIMIT-th edge after the unlock edge
	assign expire = run_reg && (cnt_reg == LAST);

	// Registers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			run_reg <= 1'b0;
			cnt_reg <= 8'h00;
		end else begin
			run_reg <= run_next;
			cnt_reg <= cnt_next;
		end
	end

endmodule : fics_unlock_timer
`default_nettype wire

// ==== tb/fics_flash_model.sv ====
// Purpose: Behavioural program flash array behind the sequencer
// Assumes: Start pulses last one cycle
// Notes:   Preloaded with a known pattern so erases and writes show
`timescale 1ns/100ps
`default_nettype none

module fics_flash_model (
	// Clock
	input wire logic        core_clk,
	// Requests
	input wire logic        flash_erase_start,
	input wire logic        flash_prog_start,
	input wire logic [13:0] flash_op_addr,
	input wire logic [7:0]  flash_op_data
);
	logic [7:0] mem [0:16383];

	// ======
	// Pattern preload: byte equals low address byte
	initial begin
		for (int i = 0; i < 16384; i++) mem[i] = i[7:0];
	end

	// Erase clears a whole 128-byte sector, program stores one byte
	always @(posedge core_clk) begin
		if (flash_erase_start) begin
			for (int i = 0; i < 128; i++) mem[{flash_op_addr[13:7], i[6:0]}] = 8'hff;
		end
		if (flash_prog_start) mem[flash_op_addr] = flash_op_data;
	end
endmodule : fics_flash_model
`default_nettype wire

// ==== tb/fics_sequencer_asserts.sv ====
// Purpose: Port-level checks of the flash command sequencer
// Assumes: Bound to fics_sequencer; one register write per cycle
// Notes:   Helper logic tracks the last command value and unlock age
`timescale 1ns/100ps
`default_nettype none
`include "fics_map.svh"

module fics_sequencer_asserts #(
	parameter int UNLOCK_CLOCKS = `FICS_UNLOCK_CLOCKS
) (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        rst_n,
	// Register bus
	input wire logic [7:0]  sfr_addr,
	input wire logic        sfr_wr,
	input wire logic [7:0]  sfr_wdata,
	// Options and outputs
	input wire logic [7:0]  cpu_freq_setting,
	input wire logic        flash_erase_start,
	input wire logic        flash_prog_start,
	input wire logic [13:0] flash_op_addr,
	input wire logic        soft_reset_req,
	input wire logic        soft_reset_reload,
	input wire logic [15:0] reset_vector,
	input wire logic        unlocked
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// ======
	// Helper: last command value, clocks since unlock (saturates so stale unlocks fail)
	logic [7:0] cmd_reg, cmd_next, age_reg, age_next;
	logic       wr_val, wr_chk, acc, go, trig_wr;
	assign wr_val = sfr_wr && (sfr_addr == `FICS_CMD_VALUE_OFS);
	assign wr_chk = sfr_wr && (sfr_addr == `FICS_CMD_CHECK_OFS);
	assign acc = wr_chk && (sfr_wdata == 8'h0f) && (cmd_reg == `FICS_CODE_UNLOCK);
	assign go = flash_erase_start || flash_prog_start;
	assign trig_wr = wr_chk && (sfr_wdata == 8'h1e) && (cmd_reg == `FICS_CODE_TRIGGER);
	always_comb begin
		cmd_next = wr_val ? sfr_wdata : cmd_reg;
		// Age counts edges after the accept edge; the lock lands when it reaches the limit
		age_next = acc ? 8'h00 : ((age_reg != 8'hff) ? age_reg + 8'h01 : age_reg);
	end
	always_ff @(posedge core_clk) begin
		cmd_reg <= rst_n ? cmd_next : 8'h00;
		age_reg <= rst_n ? age_next : 8'hff;
	end

	// ======
	// Named steps
	sequence s_unlock;
		acc;
	endsequence
	sequence s_trig_write;
		trig_wr;
	endsequence

	a_trig_start_cause: assert property (go |-> $past(trig_wr))
		else $error("flash start without trigger pair");
	a_sector_aligned: assert property (flash_erase_start |-> flash_op_addr[6:0] == 7'h00)
		else $error("erase address not sector aligned");
	a_trig_relock: assert property (go |-> !unlocked)
		else $error("still unlocked after trigger");
	a_slow_clk_block: assert property (s_trig_write ##0 (cpu_freq_setting == 8'h00) |=> !go)
		else $error("flash start below minimum clock");
	a_unlock_take: assert property (s_unlock |=> unlocked)
		else $error("unlock pair not accepted");
	a_unlock_expiry: assert property (unlocked |-> age_reg < UNLOCK_CLOCKS)
		else $error("unlock outlived its window");
	a_bad_check: assert property (wr_chk && unlocked && (sfr_wdata != ~cmd_reg) |=> !unlocked)
		else $error("bad check value did not lock");
	a_unknown_code: assert property (wr_val && unlocked && !(sfr_wdata inside {8'hf0, 8'he1,
		8'hd2, 8'hb4, 8'h87, 8'h78}) |=> !unlocked)
		else $error("unknown code did not lock");
	a_soft_cause: assert property (soft_reset_req |-> $past(wr_chk && unlocked
		&& (sfr_wdata == ~cmd_reg) && (cmd_reg inside {8'h87, 8'h78})))
		else $error("soft reset without its code pair");
	a_soft_reload: assert property (soft_reset_req |-> soft_reset_reload == ($past(cmd_reg) == 8'h78))
		else $error("soft reset reload flag wrong");
	a_keep_vector: assert property (soft_reset_req && !soft_reset_reload |-> ##2 reset_vector == 16'h0000)
		else $error("keep soft reset vector not zero");
endmodule : fics_sequencer_asserts

bind fics_sequencer fics_sequencer_asserts #(.UNLOCK_CLOCKS(UNLOCK_CLOCKS)) u_chk (
	.core_clk(core_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
	.sfr_wdata(sfr_wdata), .cpu_freq_setting(cpu_freq_setting),
	.flash_erase_start(flash_erase_start), .flash_prog_start(flash_prog_start),
	.flash_op_addr(flash_op_addr), .soft_reset_req(soft_reset_req),
	.soft_reset_reload(soft_reset_reload), .reset_vector(reset_vector), .unlocked(unlocked)
);
`default_nettype wire

// ==== tb/fics_sequencer_tb_top.sv ====
// Purpose: Self-checking bench of the flash command sequencer
// Assumes: Register writes one per cycle, inputs moved 1 ns after the edge
// Notes:   Flash array model shows the effect of erase and program
`timescale 1ns/100ps
`default_nettype none

module fics_sequencer_tb_top;
	localparam int UNL = 22;
	logic        core_clk = 1'b0, rst_n = 1'b0, por_n = 1'b0;
	logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, cpu_freq_setting = 8'h10;
	logic        sfr_wr = 1'b0, sfr_rd = 1'b0, alt_boot_vector_enable = 1'b1;
	logic [3:0]  alt_boot_vector_select = 4'h8;
	logic [7:0]  sfr_rdata, flash_op_data;
	logic        flash_erase_start, flash_prog_start, soft_reset_req, soft_reset_reload, unlocked;
	logic [13:0] flash_op_addr;
	logic [15:0] reset_vector;
	int          fail_count = 0, n_checks = 0;

	fics_sequencer #(.UNLOCK_CLOCKS(UNL)) dut (.core_clk(core_clk), .rst_n(rst_n),
		.por_n(por_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cpu_freq_setting(cpu_freq_setting),
		.alt_boot_vector_enable(alt_boot_vector_enable),
		.alt_boot_vector_select(alt_boot_vector_select),
		.flash_erase_start(flash_erase_start), .flash_prog_start(flash_prog_start),
		.flash_op_addr(flash_op_addr), .flash_op_data(flash_op_data),
		.soft_reset_req(soft_reset_req), .soft_reset_reload(soft_reset_reload),
		.reset_vector(reset_vector), .unlocked(unlocked));
	fics_flash_model u_flash (.core_clk(core_clk), .flash_erase_start(flash_erase_start),
		.flash_prog_start(flash_prog_start), .flash_op_addr(flash_op_addr),
		.flash_op_data(flash_op_data));

	// ======
	// Clock
	always #5 core_clk = ~core_clk;

	// ======
	// Access tasks: strobes stay up between back-to-back writes, idle drops them
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic step();
		@(posedge core_clk);
		#1;
	endtask : step
	task automatic idle(input int n);
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		repeat (n) step();
	endtask : idle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_wr = 1'b1;
		sfr_rd = 1'b0;
		sfr_addr = a;
		sfr_wdata = d;
		step();
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
		sfr_wr = 1'b0;
		sfr_rd = 1'b1;
		sfr_addr = a;
		step();
		chk(nm, {8'h00, exp}, {8'h00, sfr_rdata});
	endtask : rd
	task automatic cmd(input logic [7:0] v);
		wr(8'hfd, v);
		wr(8'hfc, ~v);
	endtask : cmd
	// Software order: data, unlock, address, mode, trigger with nothing between
	task automatic op(input logic [7:0] mode, input logic [7:0] hi, input logic [7:0] lo,
		input logic [7:0] d);
		wr(8'hfb, d);
		cmd(8'hf0);
		wr(8'hfa, hi);
		wr(8'hf9, lo);
		cmd(mode);
		cmd(8'he1);
	endtask : op
	task automatic test_done();
		if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : test_done

	// ======
	// Watchdog far beyond the hundred or so cycles the sequence needs
	initial begin
		repeat (5000) @(posedge core_clk);
		fail_count++;
		test_done();
	end

	// ======
	// Scenarios
	initial begin
		static logic [7:0] ofs [6] = '{8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'hfd, 8'hfe};
		static logic [7:0] rv [6] = '{8'hff, 8'h3f, 8'h00, 8'hff, 8'h00, 8'h00};
		repeat (5) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		por_n = 1'b1;
		for (int i = 0; i < 6; i++) rd(ofs[i], rv[i], "reset value");
		chk("reset_vector", 16'h1000, reset_vector);
		// Address writes while locked are dropped
		wr(8'hf9, 8'h12);
		wr(8'hfa, 8'h34);
		rd(8'hf9, 8'hff, "addr_low locked");
		rd(8'hfa, 8'h3f, "addr_high locked");
		// Erase in mid-sector address: whole aligned sector goes
		op(8'hd2, 8'h01, 8'hc5, 8'h77);
		chk("erase_start", 16'h1, flash_erase_start);
		chk("op_addr", 16'h0180, {2'b00, flash_op_addr});
		chk("unlocked", 16'h0, unlocked);
		idle(1);
		chk("erase_start", 16'h0, flash_erase_start);
		rd(8'hf9, 8'hff, "addr_low parked");
		rd(8'hfa, 8'h3f, "addr_high parked");
		chk("sector first", 16'h00ff, {8'h00, u_flash.mem[14'h0180]});
		chk("sector last", 16'h00ff, {8'h00, u_flash.mem[14'h01ff]});
		chk("below sector", 16'h007f, {8'h00, u_flash.mem[14'h017f]});
		chk("above sector", 16'h0000, {8'h00, u_flash.mem[14'h0200]});
		// Byte program
		op(8'hb4, 8'h02, 8'h33, 8'h5a);
		chk("prog_start", 16'h1, flash_prog_start);
		chk("op_addr", 16'h0233, {2'b00, flash_op_addr});
		chk("op_data", 16'h005a, {8'h00, flash_op_data});
		idle(1);
		rd(8'hfb, 8'h00, "data cleared");
		rd(8'hf9, 8'hff, "addr_low parked");
		chk("programmed byte", 16'h005a, {8'h00, u_flash.mem[14'h0233]});
		// Too slow a clock blocks the program
		cpu_freq_setting = 8'h00;
		op(8'hb4, 8'h01, 8'h11, 8'ha5);
		chk("prog_start slow", 16'h0, flash_prog_start);
		idle(1);
		cpu_freq_setting = 8'h10;
		chk("byte kept", 16'h0011, {8'h00, u_flash.mem[14'h0111]});
		// Wrong complement locks and the trigger then fails
		cmd(8'hf0);
		wr(8'hfd, 8'hd2);
		wr(8'hfc, 8'h2c);
		chk("unlocked bad check", 16'h0, unlocked);
		cmd(8'he1);
		chk("erase_start locked", 16'h0, flash_erase_start);
		// Unknown code locks at once
		cmd(8'hf0);
		wr(8'hfd, 8'h55);
		chk("unlocked unknown", 16'h0, unlocked);
		wr(8'hfc, 8'haa);
		chk("soft_req unknown", 16'h0, soft_reset_req);
		// Unlock window expires after its count
		cmd(8'hf0);
		idle(UNL - 1);
		chk("unlocked before expiry", 16'h1, unlocked);
		idle(1);
		chk("unlocked after expiry", 16'h0, unlocked);
		rd(8'hfd, 8'h00, "cmd_value expired");
		// Soft resets: keep options, then reload options
		for (int i = 0; i < 2; i++) begin
			cmd(8'hf0);
			cmd((i == 1) ? 8'h78 : 8'h87);
			chk("soft_req", 16'h1, soft_reset_req);
			chk("soft_reload", (i == 1) ? 16'h1 : 16'h0, {15'h0000, soft_reset_reload});
			idle(2);
			chk("reset_vector", (i == 1) ? 16'h1000 : 16'h0000, reset_vector);
		end
		test_done();
	end
endmodule : fics_sequencer_tb_top
`default_nettype wire
